// *** core/dhs_homing_sequencer.v ***
// Dogless homing sequencer with APB register slave
`timescale 1ns/1ps
`include "dhs_consts.vh"
module dhs_homing_sequencer #(
   parameter MOTION_CYCLE_CYC = `DHS_MOTION_CYCLE_CYC
) (
   input wire clk,
   input wire resetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire zeroPointIn,
   input wire limitSwitchIn,
   input wire axisInPositionIn,
   input wire axisStoppedIn,
   input wire encAddrZeroIn,
   output reg driveEnable,
   output reg driveDir,
   output reg creepSpeed,
   output reg decelStop,
   output reg homeMark,
   output reg homeDone,
   output reg homeError
);
   // ==========================================
   // State codes
   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_SEEK = 4'h1;
   localparam [3:0] ST_DEC_LIM = 4'h2;
   localparam [3:0] ST_BACK = 4'h3;
   localparam [3:0] ST_DEC_BACK = 4'h4;
   localparam [3:0] ST_SEEK2 = 4'h5;
   localparam [3:0] ST_DEC_Z = 4'h6;
   localparam [3:0] ST_CREEP = 4'h7;
   localparam [3:0] ST_SETTLE = 4'h8;
   localparam [3:0] ST_ERRSTOP = 4'h9;
   localparam [3:0] ST_TRAVEL = 4'hA;
   localparam [3:0] ST_DEC_T = 4'hB;
   localparam [31:0] TICK_MAX = MOTION_CYCLE_CYC - 1;

   // ==========================================
   // Input synchronisation
   wire [4:0] syncPins;
   dhs_sync #(
      .WIDTH(5)
   ) u_sync (
      .clk(clk),
      .resetn(resetn),
      .asyncIn({encAddrZeroIn, axisStoppedIn, axisInPositionIn, limitSwitchIn, zeroPointIn}),
      .syncOut(syncPins)
   );
   wire zeroLvl = syncPins[0];
   wire limitLvl = syncPins[1];
   wire inPosLvl = syncPins[2];
   wire stoppedLvl = syncPins[3];
   wire addrZeroLvl = syncPins[4];
   reg zeroLvlD;
   reg addrZeroLvlD;
   wire zeroEdge = zeroLvl & ~zeroLvlD;
   wire addrZeroEdge = addrZeroLvl & ~addrZeroLvlD;

   // ==========================================
   // Registers
   reg retryEnable;
   reg homeDirNeg;
   reg [31:0] cfgWord;
   reg [15:0] errorCode;
   reg zeroPassFlag;
   reg [3:0] state;
   reg [1:0] variant;
   reg lastZeroMode;
   reg [31:0] tickCount;
   reg motionTick;
   reg zeroPend;
   reg limitPend;
   reg addrPend;
   reg startPend;

   wire [2:0] family = cfgWord[`DHS_CFG_FAM_HI:`DHS_CFG_FAM_LO];
   wire [2:0] axisKind = cfgWord[`DHS_CFG_KIND_HI:`DHS_CFG_KIND_LO];
   wire zParam = cfgWord[`DHS_CFG_ZPARAM];
   wire semiClosed = cfgWord[`DHS_CFG_SEMI];
   wire ampless = cfgWord[`DHS_CFG_AMPLESS];
   wire [1:0] amplessMode = cfgWord[`DHS_CFG_AMODE_HI:`DHS_CFG_AMODE_LO];
   wire busy = (state != ST_IDLE);

   // ==========================================
   // APB slave
   wire apbSetup = psel & ~penable;
   wire apbAccess = psel & penable;
   wire addrHit = (paddr == `DHS_OFS_CTRL) | (paddr == `DHS_OFS_CONFIG) |
                  (paddr == `DHS_OFS_STATUS) | (paddr == `DHS_OFS_ERRCODE);
   wire apbWrite = apbAccess & pwrite & addrHit;
   assign pready = 1'b1;
   assign pslverr = apbAccess & ~addrHit;
   wire wrCtrl = apbWrite & (paddr == `DHS_OFS_CTRL);
   wire wrConfig = apbWrite & (paddr == `DHS_OFS_CONFIG);
   wire startReq = wrCtrl & pwdata[`DHS_CTRL_START];
   wire clearDoneReq = wrCtrl & pwdata[`DHS_CTRL_CLRDONE];

   always @(posedge clk) begin
      if (!resetn) begin
         prdata <= 32'h00000000;
      end else if (apbSetup & ~pwrite) begin
         case (paddr)
            `DHS_OFS_CTRL: prdata <= {28'h0000000, homeDirNeg, retryEnable, 2'h0};
            `DHS_OFS_CONFIG: prdata <= cfgWord;
            `DHS_OFS_STATUS: prdata <= {18'h00000, variant, state, 4'h0, zeroPassFlag, homeError, homeDone, busy};
            `DHS_OFS_ERRCODE: prdata <= {16'h0000, errorCode};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   always @(posedge clk) begin
      if (!resetn) begin
         retryEnable <= 1'b0;
         homeDirNeg <= 1'b0;
         cfgWord <= `DHS_CFG_RESET;
      end else begin
         if (wrCtrl) begin
            retryEnable <= pwdata[`DHS_CTRL_RETRY];
            homeDirNeg <= pwdata[`DHS_CTRL_DIRNEG];
         end
         if (wrConfig & ~busy) begin
            cfgWord <= pwdata & 32'h00003777;
         end
      end
   end

   // ==========================================
   // Motion cycle divider
   always @(posedge clk) begin
      if (!resetn) begin
         tickCount <= 32'h00000000;
         motionTick <= 1'b0;
      end else if (tickCount >= TICK_MAX) begin
         tickCount <= 32'h00000000;
         motionTick <= 1'b1;
      end else begin
         tickCount <= tickCount + 32'h00000001;
         motionTick <= 1'b0;
      end
   end

   // ==========================================
   // Event capture between motion cycles
   always @(posedge clk) begin
      if (!resetn) begin
         zeroLvlD <= 1'b0;
         addrZeroLvlD <= 1'b0;
         zeroPend <= 1'b0;
         limitPend <= 1'b0;
         addrPend <= 1'b0;
         startPend <= 1'b0;
      end else begin
         zeroLvlD <= zeroLvl;
         addrZeroLvlD <= addrZeroLvl;
         // An event in the tick cycle is consumed directly, so it must not stay pending
         zeroPend <= (zeroPend | zeroEdge) & ~motionTick;
         limitPend <= (limitPend | limitLvl) & ~motionTick;
         addrPend <= (addrPend | addrZeroEdge) & ~motionTick;
         startPend <= (startPend | startReq) & ~motionTick;
      end
   end
   wire zeroEv = zeroPend | zeroEdge;
   wire limitEv = limitPend | limitLvl;
   wire addrEv = addrPend | addrZeroEdge;
   wire startEv = startPend | startReq;

   // ==========================================
   // Variant selection
   reg [1:0] next_variant;
   reg next_lastZero;
   always @* begin
      next_variant = `DHS_VAR_B;
      next_lastZero = 1'b0;
      if (ampless) begin
         if (family == `DHS_FAM_OLDEST) begin
            next_variant = `DHS_VAR_B;
         end else if (amplessMode == 2'h3) begin
            next_variant = `DHS_VAR_B;
         end else begin
            next_variant = amplessMode;
         end
      end else begin
         case (axisKind)
            `DHS_KIND_STD: next_variant = zParam ? `DHS_VAR_B : `DHS_VAR_A;
            `DHS_KIND_DD: next_variant = zParam ? `DHS_VAR_B : `DHS_VAR_A;
            `DHS_KIND_LIN_INC: next_variant = `DHS_VAR_A;
            `DHS_KIND_LIN_ABS: next_variant = `DHS_VAR_C;
            `DHS_KIND_FC_INC: next_variant = semiClosed ? (zParam ? `DHS_VAR_B : `DHS_VAR_A) : `DHS_VAR_A;
            `DHS_KIND_FC_ABS: next_variant = semiClosed ? (zParam ? `DHS_VAR_B : `DHS_VAR_A) : `DHS_VAR_C;
            `DHS_KIND_ENC_INC: next_variant = `DHS_VAR_A;
            default: next_variant = `DHS_VAR_B;
         endcase
      end
      next_lastZero = (axisKind == `DHS_KIND_DD) | (axisKind == `DHS_KIND_ENC_INC);
   end
   wire famSupported = (family == `DHS_FAM_NEWEST) | (family == `DHS_FAM_NEWER) |
                       (family == `DHS_FAM_OLDEST) | (family == `DHS_FAM_COMPACT);

   // ==========================================
   // Sequencer
   task goError;
      input [15:0] code;
      begin
         errorCode <= code;
         homeError <= 1'b1;
         decelStop <= 1'b1;
         creepSpeed <= 1'b0;
         state <= ST_ERRSTOP;
      end
   endtask

   task goDecel;
      input [3:0] target;
      begin
         decelStop <= 1'b1;
         state <= target;
      end
   endtask

   wire startsA = startReq & ~busy & famSupported & ~homeDone & (next_variant == `DHS_VAR_A) & ~zParam;

   always @(posedge clk) begin
      if (!resetn) begin
         zeroPassFlag <= 1'b0;
      end else if (zeroEdge) begin
         zeroPassFlag <= 1'b1;
      end else if (startsA) begin
         zeroPassFlag <= 1'b0;
      end
   end

   always @(posedge clk) begin
      if (!resetn) begin
         state <= ST_IDLE;
         variant <= `DHS_VAR_A;
         lastZeroMode <= 1'b0;
         errorCode <= `DHS_ERR_NONE;
         driveEnable <= 1'b0;
         driveDir <= 1'b0;
         creepSpeed <= 1'b0;
         decelStop <= 1'b0;
         homeMark <= 1'b0;
         homeDone <= 1'b0;
         homeError <= 1'b0;
      end else begin
         homeMark <= 1'b0;
         if (clearDoneReq & ~busy) begin
            homeDone <= 1'b0;
         end
         if (motionTick) begin
            case (state)
               ST_IDLE: begin
                  if (startEv) begin
                     variant <= next_variant;
                     lastZeroMode <= next_lastZero;
                     homeError <= 1'b0;
                     errorCode <= `DHS_ERR_NONE;
                     if (!famSupported) begin
                        errorCode <= `DHS_ERR_UNSUPPORTED;
                        homeError <= 1'b1;
                     end else if (homeDone) begin
                        errorCode <= `DHS_ERR_ALREADY;
                        homeError <= 1'b1;
                     end else if ((next_variant == `DHS_VAR_A) & zParam) begin
                        errorCode <= `DHS_ERR_ZPASS_A;
                        homeError <= 1'b1;
                     end else if ((next_variant == `DHS_VAR_B) & ~zParam) begin
                        errorCode <= `DHS_ERR_ZPASS_B;
                        homeError <= 1'b1;
                     end else begin
                        driveEnable <= 1'b1;
                        driveDir <= homeDirNeg;
                        creepSpeed <= 1'b0;
                        decelStop <= 1'b0;
                        state <= (next_variant == `DHS_VAR_A) ? ST_SEEK : ST_TRAVEL;
                     end
                  end
               end
               ST_SEEK: begin
                  if (zeroEv) begin
                     homeMark <= 1'b1;
                     goDecel(ST_DEC_Z);
                  end else if (limitEv & ~retryEnable) begin
                     goError(`DHS_ERR_NO_RETRY);
                  end else if (limitEv) begin
                     goDecel(ST_DEC_LIM);
                  end
               end
               ST_DEC_LIM: begin
                  if (zeroEv) begin
                     goError(`DHS_ERR_ZERO_IN_DEC);
                  end else if (stoppedLvl) begin
                     decelStop <= 1'b0;
                     driveDir <= ~homeDirNeg;
                     state <= ST_BACK;
                  end
               end
               ST_BACK: begin
                  if (zeroEv) begin
                     // Limit still active here: axis is leaving the switch it reversed on
                     goDecel(ST_DEC_BACK);
                  end
               end
               ST_DEC_BACK: begin
                  if (stoppedLvl) begin
                     decelStop <= 1'b0;
                     driveDir <= homeDirNeg;
                     state <= ST_SEEK2;
                  end
               end
               ST_SEEK2: begin
                  if (zeroEv) begin
                     homeMark <= 1'b1;
                     goDecel(ST_DEC_Z);
                  end else if (limitEv) begin
                     goError(`DHS_ERR_LIMIT);
                  end
               end
               ST_DEC_Z: begin
                  if (limitEv) begin
                     goError(`DHS_ERR_LIMIT);
                  end else begin
                     if (zeroEv & lastZeroMode) begin
                        homeMark <= 1'b1;
                     end
                     if (stoppedLvl) begin
                        decelStop <= 1'b0;
                        creepSpeed <= 1'b1;
                        driveDir <= ~homeDirNeg;
                        state <= ST_CREEP;
                     end
                  end
               end
               ST_CREEP: begin
                  if (zeroEv) begin
                     decelStop <= 1'b1;
                     creepSpeed <= 1'b0;
                     state <= ST_SETTLE;
                  end else if (limitEv) begin
                     goError(`DHS_ERR_LIMIT);
                  end
               end
               ST_TRAVEL: begin
                  if (limitEv) begin
                     goError(`DHS_ERR_LIMIT);
                  end else if ((variant == `DHS_VAR_C) ? addrEv : zeroEv) begin
                     homeMark <= 1'b1;
                     goDecel(ST_DEC_T);
                  end
               end
               ST_DEC_T: begin
                  if (limitEv) begin
                     goError(`DHS_ERR_LIMIT);
                  end else if (stoppedLvl) begin
                     state <= ST_SETTLE;
                  end
               end
               ST_SETTLE: begin
                  if (stoppedLvl & inPosLvl) begin
                     driveEnable <= 1'b0;
                     decelStop <= 1'b0;
                     homeDone <= 1'b1;
                     state <= ST_IDLE;
                  end
               end
               ST_ERRSTOP: begin
                  if (stoppedLvl) begin
                     driveEnable <= 1'b0;
                     decelStop <= 1'b0;
                     homeDone <= 1'b0;
                     state <= ST_IDLE;
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule

// *** core/dhs_consts.vh ***
// Constants for the dogless homing sequencer
//
// Function
// - Unsupported amplifier family raises error 192, no homing
// - Restart after completed homing raises error 115
// - Variant A with Z-phase parameter 1 raises 124
// - Variant B with Z-phase parameter 0 raises 193
// - Variant A clears zero-pass flag, sets it on passage
// - Limit during post-zero deceleration: error and stop
// - Zero during post-limit deceleration with retry: error
// - Variant A limit without retry: error and stop
// - Limit first: decelerate, reverse at homing speed
// - Zero, stop, return, next zero, creep back, end
// - Linear and closed-loop end at first zero passed
// - Direct drive, encoder interface end at last zero
// - Variants B and C: any limit is error, stop
// - Variants B and C never reverse on limit
// - Fully closed loop homes as variant C if absolute, as A if incremental
// - Amplifier-less: mode setting, oldest family always B
// - Variant chosen by amplifier type and Z-phase parameter
// - Completion waits for axis in-position flag
`ifndef DHS_CONSTS_VH
`define DHS_CONSTS_VH

// ==========================================
// Register offsets
`define DHS_OFS_CTRL 8'h00
`define DHS_OFS_CONFIG 8'h04
`define DHS_OFS_STATUS 8'h08
`define DHS_OFS_ERRCODE 8'h0C

// ==========================================
// Control fields
`define DHS_CTRL_START 0
`define DHS_CTRL_CLRDONE 1
`define DHS_CTRL_RETRY 2
`define DHS_CTRL_DIRNEG 3

// ==========================================
// Configuration fields
`define DHS_CFG_FAM_LO 0
`define DHS_CFG_FAM_HI 2
`define DHS_CFG_KIND_LO 4
`define DHS_CFG_KIND_HI 6
`define DHS_CFG_ZPARAM 8
`define DHS_CFG_SEMI 9
`define DHS_CFG_AMPLESS 10
`define DHS_CFG_AMODE_LO 12
`define DHS_CFG_AMODE_HI 13
`define DHS_CFG_RESET 32'h00000100

// ==========================================
// Amplifier families
`define DHS_FAM_NEWEST 3'h0
`define DHS_FAM_NEWER 3'h1
`define DHS_FAM_OLDEST 3'h2
`define DHS_FAM_COMPACT 3'h3

// ==========================================
// Axis kinds
`define DHS_KIND_STD 3'h0
`define DHS_KIND_DD 3'h1
`define DHS_KIND_LIN_INC 3'h2
`define DHS_KIND_LIN_ABS 3'h3
`define DHS_KIND_FC_INC 3'h4
`define DHS_KIND_FC_ABS 3'h5
`define DHS_KIND_ENC_INC 3'h6

// ==========================================
// Variants
`define DHS_VAR_A 2'h0
`define DHS_VAR_B 2'h1
`define DHS_VAR_C 2'h2

// ==========================================
// Error codes
`define DHS_ERR_NONE 16'h0000
`define DHS_ERR_UNSUPPORTED 16'h00C0
`define DHS_ERR_ALREADY 16'h0073
`define DHS_ERR_ZPASS_A 16'h007C
`define DHS_ERR_ZPASS_B 16'h00C1
`define DHS_ERR_LIMIT 16'h0100
`define DHS_ERR_ZERO_IN_DEC 16'h0101
`define DHS_ERR_NO_RETRY 16'h0102

// ==========================================
// Timing
`define DHS_CLK_PERIOD_NS 5
`define DHS_MOTION_CYCLE_NS 1000000
`define DHS_MOTION_CYCLE_CYC (`DHS_MOTION_CYCLE_NS / `DHS_CLK_PERIOD_NS)

`endif

// *** core/dhs_sync.v ***
// Two-flop synchroniser bank for amplifier inputs
`timescale 1ns/1ps
module dhs_sync #(
   parameter WIDTH = 5
) (
   input wire clk,
   input wire resetn,
   input wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg stage1;
         reg stage2;
         always @(posedge clk) begin
            if (!resetn) begin
               stage1 <= 1'b0;
               stage2 <= 1'b0;
            end else begin
               stage1 <= asyncIn[i];
               stage2 <= stage1;
            end
         end
         assign syncOut[i] = stage2;
      end
   endgenerate
endmodule

// *** verification/dhs_amp_model.sv ***
// Behavioural servo amplifier with encoder, zero points and limit switch
`timescale 1ns/1ps
module dhs_amp_model (
   input wire clk,
   input wire driveEnable,
   input wire driveDir,
   input wire decelStop,
   input wire loadPos,
   input int newPos,
   input int limitPos,
   output logic zeroPoint,
   output logic limitSwitch,
   output logic inPosition,
   output logic stopped,
   output logic encZero
);
   // ==========================================
   // Axis motion, one position step per clock
   int pos;
   int decCnt;
   int settle;
   logic halt;
   initial begin
      pos = 0;
      decCnt = 0;
      settle = 0;
      halt = 1'b0;
      zeroPoint = 1'b0;
      limitSwitch = 1'b0;
      inPosition = 1'b0;
      stopped = 1'b1;
      encZero = 1'b0;
   end
   always @(posedge clk) begin
      if (loadPos)
         pos <= newPos;
      else if (driveEnable && !halt)
         pos <= driveDir ? pos - 1 : pos + 1;
      halt <= driveEnable && decelStop && (halt || decCnt >= 5);
      decCnt <= (driveEnable && decelStop && !halt) ? decCnt + 1 : 0;
      zeroPoint <= driveEnable && !halt && (pos % 64 == 0);
      encZero <= driveEnable && !halt && (pos == 0);
      limitSwitch <= pos >= limitPos;
      stopped <= !driveEnable || halt;
      settle <= stopped ? (settle < 7 ? settle + 1 : settle) : 0;
      inPosition <= stopped && settle >= 4; // Settles after standstill
   end
endmodule

// *** verification/dhs_checker_assertions.sv ***
// Port-level checker for the dogless homing sequencer
`timescale 1ns/1ps
module dhs_checker #(
   parameter MOTION_CYCLE_CYC = 8
) (
   input wire clk,
   input wire resetn,
   input wire psel,
   input wire penable,
   input wire [7:0] paddr,
   input wire pready,
   input wire pslverr,
   input wire limitSwitchIn,
   input wire axisInPositionIn,
   input wire driveEnable,
   input wire creepSpeed,
   input wire decelStop,
   input wire homeMark,
   input wire homeDone,
   input wire homeError
);
   localparam int LIM_WAIT = MOTION_CYCLE_CYC + 8;
   wire mapped;
   assign mapped = paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08 || paddr == 8'h0C;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   // ==========================================
   // Bus
   chk_ready_always: assert property (pready)
      else $error("pready low");
   chk_slverr_map: assert property (psel && penable |-> pslverr == !mapped)
      else $error("pslverr does not match address map");
   // ==========================================
   // Homing sequence
   chk_mark_single: assert property (homeMark |=> !homeMark)
      else $error("home mark longer than one clock");
   chk_mark_decel: assert property (homeMark |-> ##[0:2] decelStop)
      else $error("no deceleration after home mark");
   chk_done_inpos: assert property ($rose(homeDone) |-> axisInPositionIn && !driveEnable)
      else $error("done without in-position or with drive on");
   chk_refuse_still: assert property ($rose(homeError) && !$past(driveEnable) |-> !driveEnable)
      else $error("motion after refused start");
   chk_error_decel: assert property (homeError && driveEnable |-> decelStop)
      else $error("error stop without deceleration");
   chk_limit_react: assert property ($rose(limitSwitchIn) && driveEnable && !decelStop
      |-> ##[1:LIM_WAIT] (decelStop || !driveEnable))
      else $error("limit switch ignored");
   chk_creep_motion: assert property ($rose(creepSpeed) |-> driveEnable && !decelStop && !homeDone)
      else $error("creep without motion");
   cover property ($rose(homeDone));
   cover property ($rose(creepSpeed));
   cover property ($rose(homeError) && driveEnable);
endmodule
bind dhs_homing_sequencer dhs_checker #(.MOTION_CYCLE_CYC(MOTION_CYCLE_CYC)) dhs_checker_i (
   .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .limitSwitchIn(limitSwitchIn), .axisInPositionIn(axisInPositionIn),
   .driveEnable(driveEnable), .creepSpeed(creepSpeed), .decelStop(decelStop), .homeMark(homeMark),
   .homeDone(homeDone), .homeError(homeError));

// *** verification/tb_top.sv ***
// Self-checking testbench for the dogless homing sequencer
`timescale 1ns/1ps
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin error_cnt++; $display("mismatch %0t %h %h", $time, g, x); end end
module tb_top;
   localparam int MC = 8;
   logic clk, resetn, psel, penable, pwrite, loadPos, e, doneMdl, sawCreep, sawRev;
   logic [7:0] paddr;
   logic [31:0] pwdata, r;
   int newPos, limitPos, error_cnt, checks;
   wire [31:0] prdata;
   wire pready, pslverr, zeroPoint, limitSwitch, inPosition, stopped, encZero;
   wire driveEnable, driveDir, creepSpeed, decelStop, homeMark, homeDone, homeError;
   dhs_homing_sequencer #(.MOTION_CYCLE_CYC(MC)) dhs_homing_sequencer_i (
      .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .zeroPointIn(zeroPoint),
      .limitSwitchIn(limitSwitch), .axisInPositionIn(inPosition), .axisStoppedIn(stopped),
      .encAddrZeroIn(encZero), .driveEnable(driveEnable), .driveDir(driveDir), .creepSpeed(creepSpeed),
      .decelStop(decelStop), .homeMark(homeMark), .homeDone(homeDone), .homeError(homeError));
   dhs_amp_model dhs_amp_model_i (
      .clk(clk), .driveEnable(driveEnable), .driveDir(driveDir), .decelStop(decelStop),
      .loadPos(loadPos), .newPos(newPos), .limitPos(limitPos), .zeroPoint(zeroPoint),
      .limitSwitch(limitSwitch), .inPosition(inPosition), .stopped(stopped), .encZero(encZero));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(negedge clk) begin
      if (driveEnable === 1'b1 && creepSpeed === 1'b1) sawCreep = 1'b1;
      if (driveEnable === 1'b1 && decelStop === 1'b0 && driveDir === 1'b1) sawRev = 1'b1;
   end
   // ==========================================
   // Bus master and reference model
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 100);
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   function automatic logic [1:0] varOf(logic [31:0] c);
      if (c[10]) return (c[2:0] == 3'h2 || c[13:12] == 2'h3) ? 2'h1 : c[13:12];
      if (c[6:4] == 3'h3) return 2'h2;
      if (c[6:4] == 3'h5 && !c[9]) return 2'h2;
      if (c[6:4] == 3'h2 || c[6:4] == 3'h6 || (c[6:4] == 3'h4 && !c[9])) return 2'h0;
      return c[8] ? 2'h1 : 2'h0;
   endfunction
   function automatic logic [15:0] expErr(logic [31:0] c, logic rt, logic hit, logic dn);
      logic [1:0] v;
      v = varOf(c);
      if (c[2:0] > 3'h3) return 16'h00C0;
      if (dn) return 16'h0073;
      if (v == 2'h0 && c[8]) return 16'h007C;
      if (v == 2'h1 && !c[8]) return 16'h00C1;
      if (hit) return (v != 2'h0) ? 16'h0100 : (rt ? 16'h0000 : 16'h0102);
      return 16'h0000;
   endfunction
   // ==========================================
   // One homing run from a start position
   task automatic run(input logic [31:0] cfg, input logic rt, input int p0, input int lim, input logic clr);
      logic [15:0] xe;
      logic [1:0] xv;
      int n;
      xv = varOf(cfg);
      xe = expErr(cfg, rt, lim < 500, doneMdl && !clr);
      if (clr) begin
         apb(1'b1, 8'h00, 32'h00000002);
         doneMdl = 1'b0;
      end
      apb(1'b1, 8'h04, cfg); // Loop mode fixed for the run
      newPos <= p0; // Start off any zero point
      limitPos <= lim;
      loadPos <= 1'b1;
      @(posedge clk);
      loadPos <= 1'b0;
      sawCreep = 1'b0;
      sawRev = 1'b0;
      apb(1'b1, 8'h00, {28'h0000000, 1'b0, rt, 2'h1}); // Start with retry bit set from rt
      repeat (MC + 2) @(posedge clk);
      n = 0;
      while (!((homeDone === 1'b1 || homeError === 1'b1) && driveEnable === 1'b0) && n < 4000) begin
         @(posedge clk);
         n++;
      end
      `CHK(n < 4000, 1'b1)
      apb(1'b0, 8'h0C, 32'h0);
      `CHK(r[15:0], xe)
      apb(1'b0, 8'h08, 32'h0);
      `CHK(r[2:1], {xe != 16'h0, xe == 16'h0 || xe == 16'h0073})
      if (xe == 16'h0 || xe >= 16'h0100) `CHK(r[13:12], xv)
      if (xe == 16'h0 && xv == 2'h0) `CHK(r[3], 1'b1)
      `CHK(sawCreep, xe == 16'h0 && xv == 2'h0)
      `CHK(sawRev, xe == 16'h0 && xv == 2'h0)
      if (xe == 16'h0) doneMdl = 1'b1;
   endtask
   task conclude;
      if (error_cnt == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      conclude();
   end
   // ==========================================
   // Main sequence
   initial begin
      resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      loadPos = 1'b0; newPos = 0; limitPos = 1000; error_cnt = 0; checks = 0; doneMdl = 1'b0;
      sawCreep = 1'b0; sawRev = 1'b0;
      void'($urandom(73149));
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      apb(1'b0, 8'h04, 32'h0);
      `CHK(r, 32'h00000100)
      apb(1'b1, 8'h08, 32'hFFFFFFFF);
      apb(1'b0, 8'h08, 32'h0);
      `CHK(r, 32'h00000000)
      apb(1'b0, 8'h10 + 8'(($urandom % 60) * 4), 32'h0);
      `CHK({e, r}, 33'h100000000)
      run(32'h00000000, 1'b1, 10, 30, 1'b0);
      run(32'h00000000, 1'b0, 10, 30, 1'b1);
      run(32'h00000000, 1'b1, -20 - int'($urandom % 30), 1000, 1'b1);
      run(32'h00000100, 1'b0, -20, 1000, 1'b1);
      run(32'h00000100, 1'b0, -20, 1000, 1'b0);
      run(32'h00000100, 1'b1, 10, 30, 1'b1);
      run(32'h00000130, 1'b0, -20, 1000, 1'b1);
      run(32'h00000130, 1'b1, 10, 30, 1'b1);
      run(32'h00000050, 1'b0, -20, 1000, 1'b1);
      run(32'h00000350, 1'b0, -20, 1000, 1'b1);
      run(32'h00000104 | ($urandom % 4), 1'b0, -20, 1000, 1'b1);
      run(32'h00000501, 1'b1, -20, 1000, 1'b1);
      run(32'h00002402, 1'b0, -20, 1000, 1'b1);
      run(32'h00002500, 1'b0, -20, 1000, 1'b1);
      conclude();
   end
endmodule
